// *** src/ccc_pins.sv ***
/*
  Control and status pin logic of a multi-output clock device.
  Assumes every pin input is synchronous to clk after the two-flop
  stage here; the serial engine, PLL and dividers sit outside and
  read the qualified controls this block produces.
  Pin map of the synchroniser vector, low bit first: hardware reset,
  power-down, output enable, divider sync, serial select, then the
  reference select pins. Each stage resets to the level that the pin's
  internal pull gives it, so an open pin never looks like an edge.
  Limitation: every pin is seen two to three clocks late. The shared
  address / chip-select pin is therefore passed through raw, because the
  serial engine samples it on its own timing.
  The configuration write port is a plain strobe from the serial
  engine; only the signalling-level bit is held here.
  The manual-mode flag and the register-chosen reference come from
  inside the device and are already on this clock.
  The status sources are levels from the core on this clock as well.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ccc_pins_defs.svh"

module ccc_pins
  import ccc_pins_pkg::*;
#(
  parameter int REFSEL_W = `CCC_REFSEL_W,     // Reference select width
  parameter int STAT_W   = 4                  // Number of status sources
) (
  input  wire logic                clk,                       // 125 MHz clock
  input  wire logic                rst_n,                     // Async reset, active low
  input  wire logic                hw_reset_n,                // Hardware reset pin
  input  wire logic                power_down_n,              // Power-down pin
  input  wire logic                output_enable_n,           // Output enable pin
  input  wire logic                divider_sync_n,            // Divider sync pin
  input  wire logic [REFSEL_W-1:0] ref_sel_pins,              // Reference select pins
  input  wire logic                manual_mode,               // Pin-controlled mode
  input  wire logic                serial_sel,                // 1 two-wire, 0 SPI
  input  wire logic                addr_low_or_chip_select_n, // Shared address / CS pin
  input  wire logic                pll_locked,                // PLL lock from core
  input  wire logic [STAT_W-1:0]   status_in,                 // Internal status sources
  input  wire logic                irq_clear,                 // Status read/clear pulse
  input  wire logic [15:0]         cfg_addr,                  // Serial register address
  input  wire logic [7:0]          cfg_wdata,                 // Serial write data
  input  wire logic                cfg_we,                    // Serial write strobe
  input  wire logic [REFSEL_W-1:0] ref_sel_reg,               // Register-chosen reference
  output logic                     bus_is_i2c,                // Serial mode
  output logic                     i2c_addr_bit0,             // Address bit 0
  output logic                     spi_chip_sel,              // SPI select, active high
  output logic                     irq_out_n,                 // Interrupt, active low
  output logic                     low_power,                 // Low-power mode
  output logic                     core_reset,                // Internal logic reset
  output logic                     clk_out_en,                // Clock outputs enable
  output logic                     lock_indicator,            // High when locked
  output logic                     divider_reset,             // Divider reset
  output logic [REFSEL_W-1:0]      ref_active,                // Active reference input
  output logic                     io_is_1v8                  // Pin signalling level
);

  localparam int NSYNC = 5 + REFSEL_W;

  logic [NSYNC-1:0] rawIn;
  logic [NSYNC-1:0] meta_q;
  logic [NSYNC-1:0] sync_q;
  assign rawIn = {ref_sel_pins, serial_sel, divider_sync_n,
                  output_enable_n, power_down_n, hw_reset_n};

  // Idle level of synchroniser stage idx: pulled-up pins rest high, the
  // output enable and reference select pins rest low. Both flops use it.
  function automatic logic pinIdleLevel(input int idx);
    logic lvl;
    lvl = 1'b0;
    case (idx)
      0, 1, 3, 4: lvl = 1'b1;
      default:    lvl = 1'b0;
    endcase
    return lvl;
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      // Pull-up inputs idle high, pull-down inputs idle low
      localparam logic RST_V = pinIdleLevel(gi);
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_q[gi] <= RST_V;
          sync_q[gi] <= RST_V;
        end else begin
          // First flop may go metastable; only the second flop reads it
          meta_q[gi] <= rawIn[gi];
          sync_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  // Name the settled pin levels; the reset pin is turned active high here
  // so that the state logic reads naturally
  logic hwRst;
  logic pdnSync;
  logic oeSyncN;
  logic syncSyncN;
  logic selSync;
  logic [REFSEL_W-1:0] refSync;
  assign hwRst     = ~sync_q[0];
  assign pdnSync   = sync_q[1];
  assign oeSyncN   = sync_q[2];
  assign syncSyncN = sync_q[3];
  assign selSync   = sync_q[4];
  assign refSync   = sync_q[NSYNC-1:5];

  // Device state, reset has priority over power-down
  ccc_state_t state_q;
  ccc_state_t state_d;
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      // Leave reset straight into the mode that the power-down pin asks for
      CCC_ST_RESET: begin
        if (!hwRst) begin
          if (pdnSync) begin
            state_d = CCC_ST_RUN;
          end else begin
            state_d = CCC_ST_SLEEP;
          end
        end
      end
      // Normal operation
      CCC_ST_RUN: begin
        if (hwRst) begin
          state_d = CCC_ST_RESET;
        end else if (!pdnSync) begin
          state_d = CCC_ST_SLEEP;
        end
      end
      // Low-power mode; a hardware reset still takes over at once
      CCC_ST_SLEEP: begin
        if (hwRst) begin
          state_d = CCC_ST_RESET;
        end else if (pdnSync) begin
          state_d = CCC_ST_RUN;
        end
      end
      // The fourth code of the two-bit state cannot be reached; recover
      default: begin
        state_d = CCC_ST_RESET;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= CCC_ST_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  logic regClr;
  assign regClr = (state_q == CCC_ST_RESET);
  assign core_reset = regClr;

  assign low_power = (state_q == CCC_ST_SLEEP);

  // A write during hardware reset is dropped rather than queued: the
  // reset would clear it anyway, and the host must rewrite the level
  // once the device is out of reset.
  // signalling level bit, cleared by hardware reset
  logic ioSel_q;
  logic cfgHit;
  assign cfgHit = cfg_we && (cfg_addr == `CCC_IO_VDD_SEL_ADDR) && !regClr;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ioSel_q <= `CCC_IO_VDD_SEL_RST;
    end else if (regClr) begin
      ioSel_q <= `CCC_IO_VDD_SEL_RST;
    end else if (cfgHit) begin
      ioSel_q <= cfg_wdata[`CCC_IO_VDD_SEL_BIT];
    end
  end
  assign io_is_1v8 = ioSel_q;

  ccc_bus_mode_t busMode;
  assign busMode    = selSync ? CCC_BUS_I2C : CCC_BUS_SPI;
  assign bus_is_i2c = (busMode == CCC_BUS_I2C);

  // shared address / chip-select pin, passed raw for serial timing
  assign i2c_addr_bit0 = bus_is_i2c & addr_low_or_chip_select_n;
  assign spi_chip_sel  = ~bus_is_i2c & ~addr_low_or_chip_select_n;

  // Outputs come up one clock after the state reaches normal operation,
  // which keeps the enable free of decode glitches
  // output gating; registered so outputs never glitch
  logic outEn_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      outEn_q <= 1'b0;
    end else begin
      outEn_q <= (state_q == CCC_ST_RUN) && !hwRst && !oeSyncN;
    end
  end
  assign clk_out_en = outEn_q;

  // Forced low in reset so that the pin never claims lock while the
  // loop is being restarted
  // lock indicator
  logic lock_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_q <= 1'b0;
    end else begin
      lock_q <= pll_locked && !regClr;
    end
  end
  assign lock_indicator = lock_q;

  // Holding the dividers in reset through a device reset means that they
  // all start from the same phase when the outputs come up
  // divider reset while sync low, also held during reset
  logic divRst_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      divRst_q <= 1'b1;
    end else begin
      divRst_q <= !syncSyncN || regClr;
    end
  end
  assign divider_reset = divRst_q;

  // The mode flag is internal and already on this clock; only the pins
  // need the synchroniser
  // reference choice: pins in manual mode, else register
  logic [REFSEL_W-1:0] ref_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_q <= REFSEL_W'(`CCC_REFSEL_RST);
    end else if (regClr) begin
      ref_q <= REFSEL_W'(`CCC_REFSEL_RST);
    end else if (manual_mode) begin
      ref_q <= refSync;
    end else begin
      ref_q <= ref_sel_reg;
    end
  end
  assign ref_active = ref_q;

  // The lock indicator counts as a status source, so loss of lock also
  // raises the interrupt; changes during reset are not reported
  // status change detect; a new change wins over a clear
  logic [STAT_W:0] statPrev_q;
  logic [STAT_W:0] statNow;
  logic            irqPend_q;
  logic            statChg;
  assign statNow = {lock_q, status_in};
  assign statChg = (statNow != statPrev_q) && !regClr;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      statPrev_q <= '0;
      irqPend_q  <= 1'b0;
    end else begin
      statPrev_q <= statNow;
      if (regClr) begin
        irqPend_q <= 1'b0;
      end else if (statChg) begin
        irqPend_q <= 1'b1;
      end else if (irq_clear) begin
        irqPend_q <= 1'b0;
      end
    end
  end
  assign irq_out_n = ~irqPend_q;

endmodule // ccc_pins

`default_nettype wire

// *** inc/ccc_pins_defs.svh ***
/*
  Constants for the clock chip control-pin block: bit positions,
  reset values and synchroniser depth.
  Assumes inclusion by bare name from the package or a design file.
*/
`ifndef CCC_PINS_DEFS_SVH
`define CCC_PINS_DEFS_SVH

// Address-select / chip-select shared pin
`define CCC_ADDR_BASE_RST      7'h68
`define CCC_IO_VDD_SEL_BIT     0
`define CCC_IO_VDD_SEL_ADDR    16'h0943
`define CCC_IO_VDD_SEL_RST     1'h0
`define CCC_SYNC_STAGES        2
`define CCC_REFSEL_W           2
`define CCC_REFSEL_RST         2'h0
`define CCC_SYNC_PULSE_CYC     4'h4

`endif

// *** inc/ccc_pins_pkg.sv ***
/*
  Types for the clock chip control-pin block.
  Assumes ccc_pins_defs.svh on the include path.
*/
`include "ccc_pins_defs.svh"

package ccc_pins_pkg;
  typedef enum logic {CCC_BUS_SPI, CCC_BUS_I2C} ccc_bus_mode_t;
  typedef enum logic [1:0] {CCC_ST_RESET, CCC_ST_RUN, CCC_ST_SLEEP} ccc_state_t;
endpackage

// *** sim/ccc_pins_asserts.sv ***
/* Assertions on the ports of ccc_pins.
   Bound from the bench top; single clock domain. */
`timescale 1ns/1ps
`default_nettype none
module ccc_pins_asserts #(
  parameter int REFSEL_W = 2, // Reference select width
  parameter int STAT_W   = 4  // Status sources
) (
  // Ports grouped to keep the file short; all mirror ccc_pins
  input wire logic clk, rst_n, power_down_n, output_enable_n, divider_sync_n, manual_mode, serial_sel,
  input wire logic addr_low_or_chip_select_n, pll_locked, cfg_we, bus_is_i2c, i2c_addr_bit0, spi_chip_sel,
  input wire logic irq_out_n, low_power, core_reset, clk_out_en, lock_indicator, divider_reset, io_is_1v8,
  input wire logic [REFSEL_W-1:0] ref_sel_pins, ref_active,
  input wire logic [STAT_W-1:0]   status_in,
  input wire logic [15:0]         cfg_addr,
  input wire logic [7:0]          cfg_wdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Shared pin decode, checked in the same cycle because the pin is passed raw
  addr_pin_a: assert property (bus_is_i2c |-> i2c_addr_bit0 == addr_low_or_chip_select_n && !spi_chip_sel)
    else $error("address pin decode wrong");
  bus_mode_a: assert property (serial_sel [*3] |-> bus_is_i2c)
    else $error("bus mode wrong");
  irq_set_a: assert property ($changed(status_in) && !core_reset |=> !irq_out_n)
    else $error("interrupt not raised");
  sleep_a: assert property ($fell(power_down_n) |-> ##[1:4] low_power)
    else $error("low power not entered");
  hw_reset_a: assert property (core_reset [*2] |-> !clk_out_en)
    else $error("outputs on in reset");
  oe_off_a: assert property (output_enable_n [*5] |-> !clk_out_en)
    else $error("outputs on while disabled");
  lock_a: assert property (!core_reset |=> lock_indicator == $past(pll_locked))
    else $error("lock indicator wrong");
  sync_a: assert property ($fell(divider_sync_n) |-> ##[1:4] divider_reset)
    else $error("divider reset missing");
  ref_sel_a: assert property ((manual_mode && !core_reset && $stable(ref_sel_pins)) [*5] |-> ref_active == ref_sel_pins)
    else $error("reference choice wrong");
  io_cfg_a: assert property (cfg_we && cfg_addr == 16'h0943 && !core_reset |=> io_is_1v8 == $past(cfg_wdata[0]))
    else $error("io level bit wrong");
  // Main scenarios reached
  cover property ($fell(irq_out_n));
  cover property ($rose(low_power));
  cover property ($rose(core_reset));
endmodule // ccc_pins_asserts
`default_nettype wire

// *** sim/ccc_host.sv ***
/* Host-side pin model for ccc_pins.
   Pins rest at their pull levels; the bench moves them at falling edges. */
`timescale 1ns/1ps
`default_nettype none
module ccc_host (
  output logic       hw_reset_n,                // Reset pin
  output logic       power_down_n,              // Power-down pin
  output logic       output_enable_n,           // Output enable pin
  output logic       divider_sync_n,            // Sync pin
  output logic       serial_sel,                // Bus select pin
  output logic       addr_low_or_chip_select_n, // Shared pin
  output logic [1:0] ref_sel_pins               // Reference select pins
);
  initial begin
    {hw_reset_n, power_down_n, divider_sync_n, serial_sel, addr_low_or_chip_select_n} = 5'h1f;
    output_enable_n = 1'h0;
    ref_sel_pins = 2'h0;
  end
endmodule // ccc_host
`default_nettype wire

// *** sim/test_ccc_pins.sv ***
/* Self-checking bench for ccc_pins with the host pin model.
   Stand-alone top; binds the checker at the foot. */
`timescale 1ns/1ps
`default_nettype none
module test_ccc_pins;
  logic clk, rst_n, manual_mode, pll_locked, irq_clear, cfg_we, hw_reset_n, power_down_n, output_enable_n;
  logic divider_sync_n, serial_sel, addr_low_or_chip_select_n, bus_is_i2c, i2c_addr_bit0, spi_chip_sel;
  logic irq_out_n, low_power, core_reset, clk_out_en, lock_indicator, divider_reset, io_is_1v8;
  logic [3:0] status_in;
  logic [15:0] cfg_addr;
  logic [7:0] cfg_wdata;
  logic [1:0] ref_sel_reg, ref_sel_pins, ref_active;
  int n_mismatch = 0, total_checks = 0;
  ccc_pins u_ccc_pins (.*);
  ccc_host u_ccc_host (.*);
  // Inputs move on falling edges so sampling never races
  task automatic w(int n); repeat (n) @(negedge clk); endtask
  task automatic chk(string nm, logic [3:0] e, logic [3:0] g);
    total_checks++;
    if (g !== e) begin n_mismatch++; $display("[FAIL] %s expected %h seen %h", nm, e, g); end
  endtask
  task automatic wr(logic [15:0] a, logic [7:0] d);
    cfg_addr = a; cfg_wdata = d; cfg_we = 1; w(1); cfg_we = 0; w(1);
  endtask
  task automatic t_bus();
    for (int m = 0; m < 4; m++) begin
      u_ccc_host.serial_sel = m[1]; u_ccc_host.addr_low_or_chip_select_n = m[0]; w(4);
      chk("i2c_addr_bit0", m[1] & m[0], i2c_addr_bit0);
      chk("spi_chip_sel", !m[1] & !m[0], spi_chip_sel);
      chk("bus_is_i2c", m[1], bus_is_i2c);
    end
    $display("bus test done");
  endtask
  task automatic t_irq();
    status_in = 4'h5; w(2); chk("irq_out_n", 0, irq_out_n);
    irq_clear = 1; w(1); irq_clear = 0; w(1); chk("irq_out_n", 1, irq_out_n);
    pll_locked = 1; w(3); chk("lock_indicator", 1, lock_indicator);
    chk("irq_out_n", 0, irq_out_n);
    irq_clear = 1; w(1); irq_clear = 0; pll_locked = 0; w(2); chk("lock_indicator", 0, lock_indicator);
    irq_clear = 1; w(1); irq_clear = 0; $display("irq test done");
  endtask
  task automatic t_lvl();
    u_ccc_host.power_down_n = 0; w(6); chk("low_power", 1, low_power);
    u_ccc_host.power_down_n = 1; u_ccc_host.output_enable_n = 1; w(6); chk("low_power", 0, low_power);
    chk("clk_out_en", 0, clk_out_en);
    u_ccc_host.output_enable_n = 0; u_ccc_host.divider_sync_n = 0; w(6); chk("clk_out_en", 1, clk_out_en);
    chk("divider_reset", 1, divider_reset);
    u_ccc_host.divider_sync_n = 1; w(6); chk("divider_reset", 0, divider_reset);
    $display("level test done");
  endtask
  task automatic t_ref();
    manual_mode = 1;
    for (int r = 0; r < 4; r++) begin
      u_ccc_host.ref_sel_pins = r[1:0]; w(5); chk("ref_active", r[1:0], ref_active);
    end
    manual_mode = 0; u_ccc_host.ref_sel_pins = 0; ref_sel_reg = 2'h2; w(5); chk("ref_active", 2, ref_active);
    $display("ref test done");
  endtask
  task automatic t_cfg();
    wr(16'h0943, 8'h01); chk("io_is_1v8", 1, io_is_1v8);
    wr(16'h0942, 8'h00); chk("io_is_1v8", 1, io_is_1v8);
    wr(16'h0943, 8'hfe); chk("io_is_1v8", 0, io_is_1v8);
    wr(16'h0943, 8'h01); u_ccc_host.hw_reset_n = 0; w(6); chk("core_reset", 1, core_reset);
    chk("clk_out_en", 0, clk_out_en);
    chk("io_is_1v8", 0, io_is_1v8);
    wr(16'h0943, 8'h01); u_ccc_host.hw_reset_n = 1; w(6); chk("io_is_1v8", 0, io_is_1v8);
    chk("clk_out_en", 1, clk_out_en);
    $display("reset test done");
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  initial begin
    {rst_n, manual_mode, pll_locked, irq_clear, cfg_we, status_in, cfg_addr, cfg_wdata, ref_sel_reg} = '0;
    w(6); rst_n = 1; w(3);
    t_bus(); t_irq(); t_lvl(); t_ref(); t_cfg();
    print_verdict();
  end
  // Tests need about 107 cycles; this cuts a hang well past that
  initial begin
    #20000 n_mismatch++;
    print_verdict();
  end
endmodule // test_ccc_pins
bind ccc_pins ccc_pins_asserts #(.REFSEL_W(REFSEL_W), .STAT_W(STAT_W)) u_ccc_pins_asserts (.*);
`default_nettype wire
